// File: inc/rgc_defines.vh
// Constants shared by the region access checkers
`ifndef RGC_DEFINES_VH
`define RGC_DEFINES_VH
`define RGC_SYS_REGIONS 16
`define RGC_CORE_REGIONS 24
`define RGC_MASTERS 4
`define RGC_ADDR_W 32
// Rights bits within a per-master field
`define RGC_RT_RD 0
`define RGC_RT_WR 1
`define RGC_RT_W 2
// Core rights field: user rights in low pair, supervisor in high pair
`define RGC_CRT_W 4
`define RGC_CRT_SUP 2
// Response codes
`define RGC_RESP_OK 1'b0
`define RGC_RESP_ERR 1'b1
`endif

// File: src/rgc_core_guard.v
// Per-core region guard: 24 descriptors checked by privilege level
`timescale 1ns/1ps
`include "rgc_defines.vh"
module rgc_core_guard #(
  parameter NREG = `RGC_CORE_REGIONS,
  parameter AW = `RGC_ADDR_W
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Descriptor table, flattened
  input wire [NREG*AW-1:0] cdesc_start,
  input wire [NREG*AW-1:0] cdesc_end,
  input wire [NREG-1:0] cdesc_valid,
  input wire [NREG*`RGC_CRT_W-1:0] cdesc_rights,
  // Core access
  input wire c_req,
  input wire [AW-1:0] c_addr,
  input wire c_write,
  input wire c_super,
  // Decision
  output reg c_grant_reg,
  output reg c_block_reg
);
  reg [NREG-1:0] hit;
  reg any_ok;
  integer i;
  always @* begin
    hit = {NREG{1'b0}};
    for (i = 0; i < NREG; i = i + 1) begin
      if (cdesc_valid[i] && c_addr >= cdesc_start[i*AW +: AW] &&
          c_addr <= cdesc_end[i*AW +: AW]) begin
        hit[i] = cdesc_rights[i*`RGC_CRT_W + (c_super ? `RGC_CRT_SUP : 0)
                 + (c_write ? `RGC_RT_WR : `RGC_RT_RD)];
      end
    end
    any_ok = |hit;
  end
  always @(posedge clk_sys) begin
    if (rst) begin
      c_grant_reg <= 1'b0;
      c_block_reg <= 1'b0;
    end else begin
      c_grant_reg <= c_req & any_ok;
      c_block_reg <= c_req & ~any_ok;
    end
  end
endmodule

// File: src/rgc_region_checker.v
// System region guard at the crossbar switch, with per-core guard
`timescale 1ns/1ps
`include "rgc_defines.vh"
// How it works
// - sixteen system regions, one descriptor each
// - rights held per master per region
// - permitted transfers forwarded to the slave
// - unmapped or unpermitted transfers get error response
// - every crossbar transfer is checked
// - all descriptors compared in parallel
// - core guard holds twenty-four descriptors
// - core accesses checked concurrently
// - core access completes only if permitted
// - core decision follows task privilege
module rgc_region_checker #(
  parameter NREG = `RGC_SYS_REGIONS,
  parameter NCREG = `RGC_CORE_REGIONS,
  parameter NM = `RGC_MASTERS,
  parameter AW = `RGC_ADDR_W,
  parameter MW = 2
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // System descriptors, flattened
  input wire [NREG*AW-1:0] sdesc_start,
  input wire [NREG*AW-1:0] sdesc_end,
  input wire [NREG-1:0] sdesc_valid,
  input wire [NREG*NM*`RGC_RT_W-1:0] sdesc_rights,
  // Master side transfer
  input wire m_req,
  input wire [AW-1:0] m_addr,
  input wire m_write,
  input wire [MW-1:0] m_master,
  // Slave side
  output reg s_req_reg,
  output reg [AW-1:0] s_addr_reg,
  output reg s_write_reg,
  // Response to master
  output reg m_resp_valid_reg,
  output reg m_resp_err_reg,
  // Core guard table
  input wire [NCREG*AW-1:0] cdesc_start,
  input wire [NCREG*AW-1:0] cdesc_end,
  input wire [NCREG-1:0] cdesc_valid,
  input wire [NCREG*`RGC_CRT_W-1:0] cdesc_rights,
  // Core access
  input wire c_req,
  input wire [AW-1:0] c_addr,
  input wire c_write,
  input wire c_super,
  output wire c_grant_reg,
  output wire c_block_reg
);
  // Address inside an inclusive range
  function in_range;
    input [AW-1:0] a;
    input [AW-1:0] lo;
    input [AW-1:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  reg [NREG-1:0] match;
  reg [NREG-1:0] grant;
  reg allow;
  integer i;
  // one comparator per descriptor, no search
  always @* begin
    match = {NREG{1'b0}};
    grant = {NREG{1'b0}};
    for (i = 0; i < NREG; i = i + 1) begin
      match[i] = sdesc_valid[i] &&
                 in_range(m_addr, sdesc_start[i*AW +: AW], sdesc_end[i*AW +: AW]);
      grant[i] = match[i] & sdesc_rights[(i*NM + m_master)*`RGC_RT_W +
                 (m_write ? `RGC_RT_WR : `RGC_RT_RD)];
    end
    // overlapping regions grant if any does
    allow = |grant;
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      s_req_reg <= 1'b0;
      s_addr_reg <= {AW{1'b0}};
      s_write_reg <= 1'b0;
      m_resp_valid_reg <= 1'b0;
      m_resp_err_reg <= `RGC_RESP_OK;
    end else begin
      s_req_reg <= m_req & allow;
      s_addr_reg <= m_addr;
      s_write_reg <= m_write;
      m_resp_valid_reg <= m_req & ~allow;
      m_resp_err_reg <= (m_req & ~allow) ? `RGC_RESP_ERR : `RGC_RESP_OK;
    end
  end

  // per-core guard with its own table
  rgc_core_guard #(
    .NREG(NCREG),
    .AW(AW)
  ) u_core (
    .clk_sys(clk_sys),
    .rst(rst),
    .cdesc_start(cdesc_start),
    .cdesc_end(cdesc_end),
    .cdesc_valid(cdesc_valid),
    .cdesc_rights(cdesc_rights),
    .c_req(c_req),
    .c_addr(c_addr),
    .c_write(c_write),
    .c_super(c_super),
    .c_grant_reg(c_grant_reg),
    .c_block_reg(c_block_reg)
  );
endmodule

// File: sim/rgc_master_model.sv
// Bus master model for the crossbar side
`timescale 1ns/1ps
module rgc_master_model (
  // Clock and next transfer
  input wire clk_sys,
  input wire [35:0] nxt,
  // Transfer to the checker
  output reg m_req = 0,
  output reg m_write = 0,
  output reg [1:0] m_master = 0,
  output reg [31:0] m_addr = 0
);
  // Launch on the falling edge, held a full cycle
  always @(negedge clk_sys) {m_req, m_write, m_master, m_addr} <= nxt;
endmodule

// File: sim/rgc_region_checker_asserts.sv
// Decision timing checks of the region checker
`timescale 1ns/1ps
module rgc_chk (
  // Clock, reset, requests
  input wire clk_sys,
  input wire rst,
  input wire m_req,
  input wire [31:0] m_addr,
  input wire c_req,
  // Decisions
  input wire s_req_reg,
  input wire [31:0] s_addr_reg,
  input wire m_resp_valid_reg,
  input wire m_resp_err_reg,
  input wire c_grant_reg,
  input wire c_block_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_ans; m_req |=> s_req_reg ^ m_resp_valid_reg; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_idl; !m_req |=> !s_req_reg && !m_resp_valid_reg; endproperty
  a_idl: assert property (p_idl) else $error("stray");
  property p_err; m_resp_err_reg == m_resp_valid_reg; endproperty
  a_err: assert property (p_err) else $error("err flag");
  property p_adr; s_req_reg |-> s_addr_reg == $past(m_addr); endproperty
  a_adr: assert property (p_adr) else $error("addr");
  property p_b2b; m_req [*2] |=> $past(s_req_reg | m_resp_valid_reg); endproperty
  a_b2b: assert property (p_b2b) else $error("gap");
  property p_cans; c_req |=> c_grant_reg ^ c_block_reg; endproperty
  a_cans: assert property (p_cans) else $error("core answer");
  property p_cidl; !c_req |=> !c_grant_reg && !c_block_reg; endproperty
  a_cidl: assert property (p_cidl) else $error("core stray");
  property p_cb2b; c_req [*2] |=> $past(c_grant_reg | c_block_reg); endproperty
  a_cb2b: assert property (p_cb2b) else $error("core gap");
endmodule
bind rgc_region_checker rgc_chk chk_u (.*);

// File: sim/tb_rgc_region_checker.sv
// Random bench of the region checker
`timescale 1ns/1ps
module tb_rgc_region_checker;
  reg clk_sys = 1, rst = 1, c_req = 0, c_write = 0, c_super = 0;
  reg [31:0] c_addr = 0, r;
  reg [35:0] nxt = 0;
  reg [767:0] cdesc_start, cdesc_end;
  reg [511:0] sdesc_start, sdesc_end;
  reg [127:0] sdesc_rights;
  reg [23:0] cdesc_valid;
  reg [15:0] sdesc_valid;
  integer seed = 4340, k, fail_count = 0, samples_checked = 0;
  wire m_req, m_write, s_req_reg, m_resp_err_reg, c_grant_reg, c_block_reg;
  wire m_resp_valid_reg, s_write_reg;
  wire [1:0] m_master;
  wire [31:0] m_addr, s_addr_reg;
  wire [95:0] cdesc_rights = sdesc_rights[95:0];
  rgc_master_model bus_u (.*);
  rgc_region_checker dut_u (.*);
  // Clock and watchdog
  initial forever #25 clk_sys = ~clk_sys;
  initial begin
    #150000 fail_count = fail_count + 1;
    finish_test;
  end
  // Overlapping regions: any granting one allows
  function [1:0] exp_fn();
    exp_fn = 0;
    for (k = 0; k < 24; k = k + 1) begin
      if (k < 16 && sdesc_valid[k] && m_addr >= 256 * k && m_addr < 256 * k + 512
          && sdesc_rights[k * 8 + m_master * 2 + m_write]) exp_fn[0] = 1;
      if (cdesc_valid[k] && c_addr >= 256 * k && c_addr < 256 * k + 512
          && cdesc_rights[k * 4 + c_super * 2 + c_write]) exp_fn[1] = 1;
    end
  endfunction
  task check(input [4:0] x, input [4:0] y);
    samples_checked = samples_checked + 1;
    if (x !== y) begin
      fail_count = fail_count + 1;
      $display("FAIL decision exp %b got %b", x, y);
    end
  endtask
  // Slave side copy of direction and address
  task check_addr(input [32:0] x, input [32:0] y);
    samples_checked = samples_checked + 1;
    if (x !== y) begin
      fail_count = fail_count + 1;
      $display("FAIL slave_addr exp %h got %h", x, y);
    end
  endtask
  task finish_test;
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Random rights, then random back-to-back traffic
  initial begin
    {cdesc_valid, sdesc_valid} = {$random(seed), $random(seed)};
    sdesc_rights = {$random(seed), $random(seed), $random(seed), $random(seed)};
    for (k = 0; k < 24; k = k + 1) begin
      cdesc_start[k*32+:32] = 256 * k;
      cdesc_end[k*32+:32] = 256 * k + 511;
    end
    sdesc_start = cdesc_start[511:0];
    sdesc_end = cdesc_end[511:0];
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) rst <= 0;
    repeat (2000) begin
      @(negedge clk_sys);
      // Bit 0 is the system verdict, bit 1 the core verdict
      r = {30'h0, exp_fn()};
      check({m_req & r[0], m_req & ~r[0], m_req & ~r[0], c_req & r[1], c_req & ~r[1]},
        {s_req_reg, m_resp_valid_reg, m_resp_err_reg, c_grant_reg, c_block_reg});
      check_addr({m_write, m_addr}, {s_write_reg, s_addr_reg});
      r = $random(seed);
      // System-side region edges forced when bit 13 is set
      nxt <= {r[31:28], 19'h0, r[12:8], r[13] ? {8{r[7]}} : r[7:0]};
      {c_req, c_write, c_super, c_addr} <= {r[27:25], 19'h0, r[24:12]};
    end
    finish_test;
  end
endmodule
